// File: pkg/btbm_pkg.sv
// Purpose: Constants, types and helpers for the bit test and block move unit
// Assumes: 16-bit words, bit 0 is the most significant bit of a word
// Notes: Register map is reached over APB, one aligned 32-bit word each
package btbm_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_TOS = 8'h04;
  localparam logic [7:0] ADDR_SEC = 8'h08;
  localparam logic [7:0] ADDR_THIRD = 8'h0c;
  localparam logic [7:0] ADDR_INDEX = 8'h10;
  localparam logic [7:0] ADDR_DB = 8'h14;
  localparam logic [7:0] ADDR_PB = 8'h18;
  localparam logic [7:0] ADDR_DL = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_GRP_LSB = 6;
  localparam int CMD_IDX_BIT = 8;
  localparam int CMD_PB_BIT = 9;
  localparam int CMD_B11_BIT = 10;
  localparam int CMD_PRIV_BIT = 11;
  localparam int CMD_STACK_DECREMENT_FIELD_LSB = 12;
  localparam int CMD_ARG_LSB = 16;

  localparam logic [1:0] GRP_SUB1 = 2'h0;
  localparam logic [1:0] GRP_SUB3 = 2'h1;
  localparam logic [1:0] GRP_MOVE = 2'h2;

  localparam logic [5:0] SUB1_SCAN = 6'h06;
  localparam logic [5:0] SUB1_TEST = 6'h1a;
  localparam logic [5:0] SUB1_TEST_RESET = 6'h1b;
  localparam logic [5:0] SUB1_TEST_SET = 6'h1c;
  localparam logic [5:0] SUB1_TEST_COMPL = 6'h1d;
  localparam logic [5:0] SUB3_MEM_TEST_SET = 6'h0c;
  localparam logic [5:0] MOVE_WORD = 6'h00;
  localparam logic [5:0] MOVE_BYTE = 6'h01;
  localparam logic [5:0] MOVE_BASE_LIMIT = 6'h02;

  // ---------------------------------------------------------------
  // Status word and condition code
  // ---------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_INTR = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_CC_LSB = 4;
  localparam int ST_POP_LSB = 6;

  localparam logic [1:0] CC_GREATER = 2'h0;
  localparam logic [1:0] CC_LESS = 2'h1;
  localparam logic [1:0] CC_EQUAL = 2'h2;
  localparam logic [1:0] CC_RST = CC_EQUAL;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hffff;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_SRC = 3'b001,
    ST_RD_TGT = 3'b010,
    ST_WR_TGT = 3'b011,
    ST_TS_RD = 3'b100,
    ST_TS_LOCK = 3'b101,
    ST_TS_WR = 3'b110
  } btbm_state_t;

  // Pattern A on a signed word
  function automatic logic [1:0] cond_pattern_a(input logic [15:0] w);
    if (w == WORD_RST) begin
      return CC_EQUAL;
    end else if (w[15]) begin
      return CC_LESS;
    end
    return CC_GREATER;
  endfunction

  // Byte address from a word base and signed byte displacement
  function automatic logic [16:0] byte_addr(input logic [15:0] base, input logic [15:0] disp);
    return {base, 1'b0} + {disp[15], disp};
  endfunction

endpackage

// File: hw/btbm_bit_alu.sv
// Purpose: Combinational scan and single-bit test datapath
// Assumes: Bit 0 is the most significant bit of the word
// Notes: Pure logic, the caller registers every result
`timescale 1ns/1ps
`default_nettype none
module btbm_bit_alu
  import btbm_pkg::*;
(
  input wire logic [15:0] top_stack_word,
  input wire logic [15:0] index,
  input wire logic [5:0] arg,
  input wire logic indexed,
  input wire logic [5:0] code,
  output logic [15:0] scan_tos,
  output logic [15:0] scan_index,
  output logic bit_val,
  output logic [15:0] bit_word,
  output logic [3:0] bit_n
);

  logic [15:0] sum;
  logic [15:0] mask;
  logic [4:0] lead;
  logic [4:0] shift;

  // Bit number wraps modulo 16 by keeping four bits
  assign sum = {10'h000, arg} + (indexed ? index : WORD_RST);
  assign bit_n = sum[3:0];
  assign mask = 16'h8000 >> bit_n;
  assign bit_val = |(top_stack_word & mask);
  assign shift = lead + 5'h01;

  // Leading zero count from the left end; rising index so the top one wins
  always_comb begin
    lead = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (top_stack_word[i]) begin
        lead = 5'(15 - i);
      end
    end
  end

  // Scan result: shift past the first one, count into the index
  always_comb begin
    if (top_stack_word == WORD_RST) begin
      scan_tos = WORD_RST;
      scan_index = indexed ? index + 16'h0010 : 16'h0010;
    end else begin
      scan_tos = top_stack_word << shift;
      scan_index = (indexed ? index : WORD_ONES) + {11'h000, shift};
    end
  end

  // Word after the test step of each variant
  always_comb begin
    case (code)
      SUB1_TEST_RESET: bit_word = top_stack_word & ~mask;
      SUB1_TEST_SET: bit_word = top_stack_word | mask;
      SUB1_TEST_COMPL: bit_word = top_stack_word ^ mask;
      default: bit_word = top_stack_word;
    endcase
  end

endmodule
`default_nettype wire

// File: hw/btbm_unit.sv
// Purpose: Bit test and block move execution unit with APB registers
// Assumes: Memory slave on the same clock answers with a one-cycle ack
// Notes: Stack words live in registers, so split stacks need no care
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module btbm_unit
  import btbm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_req,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  btbm_state_t state_reg, state_next;
  logic [31:0] cmd_reg;
  logic [15:0] tos_reg, sec_reg, third_reg, index_reg;
  logic [15:0] db_reg, pb_reg, dl_reg, src_reg, tgt_reg;
  logic busy_reg, done_reg, intr_reg, fault_reg;
  logic [1:0] cc_reg, pop_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic mem_req_reg, mem_we_reg;
  logic [15:0] mem_addr_reg, mem_wdata_reg;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_reg & pwrite;
  wire hit_cmd = paddr == ADDR_CMD;
  wire hit_tos = paddr == ADDR_TOS;
  wire hit_sec = paddr == ADDR_SEC;
  wire hit_third = paddr == ADDR_THIRD;
  wire hit_index = paddr == ADDR_INDEX;
  wire hit_db = paddr == ADDR_DB;
  wire hit_pb = paddr == ADDR_PB;
  wire hit_dl = paddr == ADDR_DL;
  wire hit_status = paddr == ADDR_STATUS;
  wire mapped = hit_cmd | hit_tos | hit_sec | hit_third | hit_index | hit_db | hit_pb
    | hit_dl | hit_status;
  // Operand writes are dropped while a move runs, the engine owns them
  wire wr_ok = apb_wr & ~busy_reg;
  wire start = wr_ok & hit_cmd;
  wire [15:0] wd = pwdata[15:0];
  wire [31:0] status_word = {24'h000000, pop_reg, cc_reg, fault_reg, intr_reg, done_reg,
    busy_reg};

  logic [31:0] rd_mux;
  always_comb begin
    if (hit_cmd) begin
      rd_mux = cmd_reg;
    end else if (hit_tos) begin
      rd_mux = {16'h0000, tos_reg};
    end else if (hit_sec) begin
      rd_mux = {16'h0000, sec_reg};
    end else if (hit_third) begin
      rd_mux = {16'h0000, third_reg};
    end else if (hit_index) begin
      rd_mux = {16'h0000, index_reg};
    end else if (hit_db) begin
      rd_mux = {16'h0000, db_reg};
    end else if (hit_pb) begin
      rd_mux = {16'h0000, pb_reg};
    end else if (hit_dl) begin
      rd_mux = {16'h0000, dl_reg};
    end else if (hit_status) begin
      rd_mux = status_word;
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Command fields, taken from the new word at start, except from_pb, stack_decrement_field and run_code, read from cmd_reg
  // ---------------------------------------------------------------
  wire [31:0] cmd_src = start ? pwdata : cmd_reg;
  wire [5:0] code = cmd_src[CMD_CODE_LSB +: 6];
  wire [1:0] grp = cmd_src[CMD_GRP_LSB +: 2];
  wire indexed = cmd_src[CMD_IDX_BIT];
  wire from_pb = cmd_reg[CMD_PB_BIT];
  wire bit11 = cmd_src[CMD_B11_BIT];
  wire priv = cmd_src[CMD_PRIV_BIT];
  wire [1:0] stack_decrement_field = cmd_reg[CMD_STACK_DECREMENT_FIELD_LSB +: 2];
  wire [7:0] disp8 = cmd_src[CMD_ARG_LSB +: 8];
  wire [5:0] arg6 = cmd_src[CMD_ARG_LSB +: 6];
  wire [5:0] run_code = cmd_reg[CMD_CODE_LSB +: 6];

  // Start classification
  wire is_sub1 = grp == GRP_SUB1;
  wire is_scan = is_sub1 & (code == SUB1_SCAN);
  wire is_bit = is_sub1 & (code >= SUB1_TEST) & (code <= SUB1_TEST_COMPL);
  wire is_memory_test_and_set = (grp == GRP_SUB3) & (code == SUB3_MEM_TEST_SET);
  wire is_mw = (grp == GRP_MOVE) & (code == MOVE_WORD);
  wire is_mb = (grp == GRP_MOVE) & (code == MOVE_BYTE);
  wire is_bl = (grp == GRP_MOVE) & (code == MOVE_BASE_LIMIT) & ~bit11;
  wire bl_ok = is_bl & priv;
  wire is_move = is_mw | is_mb | bl_ok;
  wire bad_cmd = ~(is_scan | is_bit | is_memory_test_and_set | is_move);
  wire byte_run = run_code == MOVE_BYTE;
  wire bl_run = run_code == MOVE_BASE_LIMIT;

  // ---------------------------------------------------------------
  // Bit datapath
  // ---------------------------------------------------------------
  logic [15:0] scan_tos, scan_index, bit_word;
  logic bit_val;
  logic [3:0] bit_n;

  btbm_bit_alu u_alu (
    .top_stack_word(tos_reg),
    .index(index_reg),
    .arg(arg6),
    .indexed(indexed),
    .code(code),
    .scan_tos(scan_tos),
    .scan_index(scan_index),
    .bit_val(bit_val),
    .bit_word(bit_word),
    .bit_n(bit_n)
  );

  // ---------------------------------------------------------------
  // Move addressing
  // ---------------------------------------------------------------
  // Source base: data base or program base, or data base for the limit move
  wire [15:0] src_base = (from_pb & ~bl_run) ? pb_reg : db_reg;
  wire [15:0] tgt_base = bl_run ? dl_reg : db_reg;
  wire [16:0] src_ba = byte_addr(src_base, sec_reg);
  wire [16:0] tgt_ba = byte_addr(tgt_base, third_reg);
  wire [15:0] src_addr = byte_run ? src_ba[16:1] : src_base + sec_reg;
  wire [15:0] tgt_addr = byte_run ? tgt_ba[16:1] : tgt_base + third_reg;
  wire [7:0] src_byte = src_ba[0] ? src_reg[7:0] : src_reg[15:8];
  wire [15:0] merged = tgt_ba[0] ? {tgt_reg[15:8], src_byte} : {src_byte, tgt_reg[7:0]};
  wire [15:0] ts_addr = db_reg + {8'h00, disp8[7:0]};

  // Count moves one step toward zero, displacements follow its sign
  wire cnt_pos = ~tos_reg[15];
  wire [15:0] cnt_step = cnt_pos ? tos_reg - 16'h0001 : tos_reg + 16'h0001;
  wire [15:0] sec_step = cnt_pos ? sec_reg + 16'h0001 : sec_reg - 16'h0001;
  wire [15:0] third_step = cnt_pos ? third_reg + 16'h0001 : third_reg - 16'h0001;

  // ---------------------------------------------------------------
  // Engine control
  // ---------------------------------------------------------------
  wire mem_state = state_reg != ST_IDLE;
  wire acked = mem_req_reg & mem_ack;
  wire xfer_end = acked & (state_reg == ST_WR_TGT);
  wire move_last = xfer_end & (cnt_step == WORD_RST);
  // Pause between transfers; operands already hold the resume point
  wire move_pause = xfer_end & ~move_last & int_req;
  wire ts_end = acked & (state_reg == ST_TS_WR);
  // A zero count finishes at the command write, nothing is transferred
  wire start_move = start & is_move & (tos_reg != WORD_RST);

  // Request fields for the current state
  wire [15:0] req_addr = (state_reg == ST_RD_SRC) ? src_addr
    : (state_reg == ST_RD_TGT || state_reg == ST_WR_TGT) ? tgt_addr : ts_addr;
  wire req_we = (state_reg == ST_WR_TGT) | (state_reg == ST_TS_LOCK)
    | (state_reg == ST_TS_WR);
  // Ones lock the semaphore cell so another processor sees it taken
  wire [15:0] req_wdata = (state_reg == ST_TS_LOCK) ? WORD_ONES
    : (state_reg == ST_TS_WR) ? (tos_reg | tgt_reg)
    : byte_run ? merged : src_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_move) begin
          state_next = ST_RD_SRC;
        end else if (start & is_memory_test_and_set) begin
          state_next = ST_TS_RD;
        end
      end
      ST_RD_SRC: if (acked) state_next = byte_run ? ST_RD_TGT : ST_WR_TGT;
      ST_RD_TGT: if (acked) state_next = ST_WR_TGT;
      ST_WR_TGT: if (acked) state_next = (move_last | move_pause) ? ST_IDLE : ST_RD_SRC;
      ST_TS_RD: if (acked) state_next = ST_TS_LOCK;
      ST_TS_LOCK: if (acked) state_next = ST_TS_WR;
      ST_TS_WR: if (acked) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // APB answer: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup & ~mapped;
      prdata_reg <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Memory request: issued one cycle after entry, held until ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= WORD_RST;
      mem_wdata_reg <= WORD_RST;
    end else if (acked) begin
      mem_req_reg <= 1'b0;
    end else if (mem_state & ~mem_req_reg) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= req_we;
      mem_addr_reg <= req_addr;
      mem_wdata_reg <= req_wdata;
    end
  end

  // Read data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= WORD_RST;
      tgt_reg <= WORD_RST;
    end else if (acked & (state_reg == ST_RD_SRC)) begin
      src_reg <= mem_rdata;
    end else if (acked & (state_reg == ST_RD_TGT || state_reg == ST_TS_RD)) begin
      tgt_reg <= mem_rdata;
    end
  end

  // Command, base pointers and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 32'h00000000;
      db_reg <= WORD_RST;
      pb_reg <= WORD_RST;
      dl_reg <= WORD_RST;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      intr_reg <= 1'b0;
      fault_reg <= 1'b0;
      pop_reg <= 2'h0;
    end else begin
      if (start) cmd_reg <= pwdata;
      if (wr_ok & hit_db) db_reg <= wd;
      if (wr_ok & hit_pb) pb_reg <= wd;
      if (wr_ok & hit_dl) dl_reg <= wd;
      if (start) begin
        busy_reg <= start_move | (is_memory_test_and_set & ~bad_cmd);
        done_reg <= ~(start_move | is_memory_test_and_set) & ~bad_cmd;
        intr_reg <= 1'b0;
        fault_reg <= bad_cmd;
        pop_reg <= (is_move & ~start_move) ? pwdata[CMD_STACK_DECREMENT_FIELD_LSB +: 2] : 2'h0;
      end else if (move_last) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
        pop_reg <= stack_decrement_field;
      end else if (move_pause) begin
        busy_reg <= 1'b0;
        intr_reg <= 1'b1;
      end else if (ts_end) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end

  // Stack words and index: software loads, the engine updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tos_reg <= WORD_RST;
      sec_reg <= WORD_RST;
      third_reg <= WORD_RST;
      index_reg <= WORD_RST;
      cc_reg <= CC_RST;
    end else if (start & is_scan) begin
      tos_reg <= scan_tos;
      index_reg <= scan_index;
      cc_reg <= cond_pattern_a(scan_tos);
    end else if (start & is_bit) begin
      tos_reg <= bit_word;
      cc_reg <= bit_val ? CC_GREATER : CC_EQUAL;
    end else if (xfer_end) begin
      tos_reg <= cnt_step;
      sec_reg <= sec_step;
      third_reg <= third_step;
    end else if (ts_end) begin
      tos_reg <= tos_reg & tgt_reg;
      cc_reg <= cond_pattern_a(tos_reg & tgt_reg);
    end else if (wr_ok) begin
      if (hit_tos) tos_reg <= wd;
      if (hit_sec) sec_reg <= wd;
      if (hit_third) third_reg <= wd;
      if (hit_index) index_reg <= wd;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_scan_zero;
    start && is_scan && !indexed && tos_reg == WORD_RST;
  endsequence

  sequence s_ts_lock_write;
    state_reg == ST_TS_LOCK && mem_req && mem_we;
  endsequence

  property p_scan_zero;
    @(posedge pclk) disable iff (!presetn)
      s_scan_zero |=> index_reg == 16'h0010 && cc_reg == CC_EQUAL;
  endproperty
  a_scan_zero: assert property (p_scan_zero) else $error("zero scan count wrong");

  property p_test_keeps;
    @(posedge pclk) disable iff (!presetn)
      start && is_bit && code == SUB1_TEST |=> $stable(tos_reg);
  endproperty
  a_test_keeps: assert property (p_test_keeps) else $error("plain test changed word");

  property p_test_reset;
    @(posedge pclk) disable iff (!presetn)
      start && is_bit && code == SUB1_TEST_RESET |=> tos_reg[15 - $past(bit_n)] == 1'b0;
  endproperty
  a_test_reset: assert property (p_test_reset) else $error("bit not cleared");

  property p_test_set;
    @(posedge pclk) disable iff (!presetn)
      start && is_bit && code == SUB1_TEST_SET |=> tos_reg[15 - $past(bit_n)] == 1'b1;
  endproperty
  a_test_set: assert property (p_test_set) else $error("bit not set");

  property p_test_compl;
    @(posedge pclk) disable iff (!presetn)
      start && is_bit && code == SUB1_TEST_COMPL
      |=> $countones(tos_reg ^ $past(tos_reg)) == 1;
  endproperty
  a_test_compl: assert property (p_test_compl) else $error("not one bit flipped");

  property p_ts_lock;
    @(posedge pclk) disable iff (!presetn)
      s_ts_lock_write |-> mem_wdata == WORD_ONES && mem_addr == ts_addr;
  endproperty
  a_ts_lock: assert property (p_ts_lock) else $error("semaphore not locked");

  property p_toward_zero;
    @(posedge pclk) disable iff (!presetn)
      xfer_end && cnt_pos |=> tos_reg == $past(tos_reg) - 16'h0001
      && sec_reg == $past(sec_reg) + 16'h0001;
  endproperty
  a_toward_zero: assert property (p_toward_zero) else $error("count step wrong");

  property p_move_cc;
    @(posedge pclk) disable iff (!presetn)
      busy_reg && state_reg != ST_TS_WR |=> $stable(cc_reg);
  endproperty
  a_move_cc: assert property (p_move_cc) else $error("move changed code");

  property p_pop;
    @(posedge pclk) disable iff (!presetn)
      move_last |=> done_reg && !busy_reg && pop_reg == $past(stack_decrement_field);
  endproperty
  a_pop: assert property (p_pop) else $error("stack delete wrong");

  property p_priv;
    @(posedge pclk) disable iff (!presetn)
      start && is_bl && !priv |=> fault_reg && !busy_reg ##1 !mem_req;
  endproperty
  a_priv: assert property (p_priv) else $error("unprivileged move ran");

endmodule
`default_nettype wire

// File: sim/btbm_mem_model.sv
// Purpose: Memory partner on the unit's word port
// Assumes: Same clock as the unit, word addresses below 256
// Notes: Ack after one or three cycles; idle data bus toggles
`timescale 1ns/1ps
`default_nettype none
module btbm_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic saw_ones
);
  logic [15:0] mem [0:255];
  logic [1:0] wait_reg;
  // ------
  // Access
  // ------
  // Idle data is inverted each cycle so a late sample shows up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      saw_ones <= 1'b0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && slow && wait_reg != 2'h2) begin
      wait_reg <= wait_reg + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      wait_reg <= 2'h0;
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
        saw_ones <= saw_ones | (mem_wdata == 16'hffff); // Lock value seen
      end else begin
        mem_rdata <= mem[mem_addr[7:0]];
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// File: sim/test_bit_test_and_block_move_unit.sv
// Purpose: Self-checking bench for the bit test and block move unit
// Assumes: Zero-wait APB answer, partner memory on the same clock
// Notes: Each command is polled on STATUS until busy drops
`timescale 1ns/1ps
`default_nettype none
module test_bit_test_and_block_move_unit;
  import btbm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_req, slow, err;
  logic mem_req, mem_we, mem_ack, saw_ones;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, msk, etos;
  int fails, tests_run;
  btbm_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .int_req, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack);
  btbm_mem_model mem_m (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .saw_ones);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] st(input logic [1:0] pop, input logic [1:0] cc);
    return {24'h0, pop, cc, 4'h2};
  endfunction
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Start a command; a stuck busy ends the run
  task automatic run(input logic [31:0] cmd);
    int n;
    apb(1'b1, ADDR_CMD, cmd);
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 40);
    if (rd[ST_BUSY] !== 1'b0) begin
      fails++;
      test_done();
    end
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, int_req, slow, presetn} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fails = 0;
    tests_run = 0;
    mem_m.mem[8'h20] = 16'h1234;
    mem_m.mem[8'h21] = 16'h5678;
    mem_m.mem[8'h62] = 16'h0000;
    mem_m.mem[8'hff] = 16'h0f0f;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    r(ADDR_STATUS, {24'h0, 2'h0, CC_RST, 4'h0});
    apb(1'b0, 8'h24, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, ADDR_TOS, 32'h1800);
    run({26'h0, SUB1_SCAN});
    r(ADDR_INDEX, 32'h3);
    r(ADDR_TOS, 32'h8000);
    r(ADDR_STATUS, st(2'h0, CC_LESS));
    apb(1'b1, ADDR_TOS, 32'h0);
    run({26'h0, SUB1_SCAN});
    r(ADDR_INDEX, 32'h10);
    apb(1'b1, ADDR_INDEX, 32'h5);
    run({23'h0, 1'b1, GRP_SUB1, SUB1_SCAN});
    r(ADDR_INDEX, 32'h15);
    // All four bit tests, bit one set unindexed, then bit two clear via index
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_TOS, 32'h4000);
      apb(1'b1, ADDR_INDEX, 32'h10);
      run({8'h0, (k < 4) ? 8'h11 : 8'h02, 7'h0, k >= 4, GRP_SUB1, SUB1_TEST + 6'(k % 4)});
      msk = (k < 4) ? 16'h4000 : 16'h2000;
      etos = (k % 4 == 1) ? 16'h4000 & ~msk : (k % 4 == 2) ? 16'h4000 | msk :
        (k % 4 == 3) ? 16'h4000 ^ msk : 16'h4000;
      r(ADDR_TOS, {16'h0, etos});
      r(ADDR_STATUS, st(2'h0, (k < 4) ? CC_GREATER : CC_EQUAL));
    end
    apb(1'b1, ADDR_DB, 32'h0);
    apb(1'b1, ADDR_TOS, 32'hff00);
    run(32'h00ff_004c);
    r(ADDR_TOS, 32'h0f00);
    r(ADDR_STATUS, st(2'h0, CC_GREATER));
    chk({16'h0, mem_m.mem[8'hff]}, 32'hff0f);
    chk({31'h0, saw_ones}, 32'h1);
    // Word move from program base, slow memory, three words deleted
    slow <= 1'b1;
    apb(1'b1, ADDR_PB, 32'h20);
    apb(1'b1, ADDR_DB, 32'h40);
    apb(1'b1, ADDR_TOS, 32'h2);
    run(32'h0000_3280);
    chk({mem_m.mem[8'h40], mem_m.mem[8'h41]}, 32'h1234_5678);
    r(ADDR_THIRD, 32'h2);
    r(ADDR_STATUS, st(2'h3, CC_GREATER));
    // Downward move paused after one word, then resumed
    slow <= 1'b0;
    int_req <= 1'b1;
    apb(1'b1, ADDR_TOS, 32'hfffe);
    apb(1'b1, ADDR_SEC, 32'h1);
    apb(1'b1, ADDR_THIRD, 32'h11);
    run(32'h0000_0080);
    chk({28'h0, rd[3:0]}, 32'h4);
    r(ADDR_TOS, 32'hffff);
    chk({16'h0, mem_m.mem[8'h51]}, 32'h5678);
    int_req <= 1'b0;
    run(32'h0000_0080);
    chk({16'h0, mem_m.mem[8'h50]}, 32'h1234);
    r(ADDR_SEC, 32'hffff);
    apb(1'b1, ADDR_TOS, 32'h1);
    apb(1'b1, ADDR_SEC, 32'h1);
    apb(1'b1, ADDR_THIRD, 32'h20);
    run(32'h0000_0081);
    chk({16'h0, mem_m.mem[8'h50]}, 32'h3434);
    r(ADDR_THIRD, 32'h21);
    // Base to limit move refused outside privileged mode
    apb(1'b1, ADDR_DL, 32'h60);
    apb(1'b1, ADDR_TOS, 32'h1);
    apb(1'b1, ADDR_SEC, 32'h1);
    apb(1'b1, ADDR_THIRD, 32'h2);
    run(32'h0000_0082);
    chk({31'h0, rd[ST_FAULT]}, 32'h1);
    run(32'h0000_0882);
    chk({16'h0, mem_m.mem[8'h62]}, 32'h5678);
    r(ADDR_STATUS, st(2'h0, CC_GREATER));
    // Count now zero: move ends at once, two words deleted
    run(32'h0000_2080);
    r(ADDR_STATUS, st(2'h2, CC_GREATER));
    r(ADDR_THIRD, 32'h3);
    test_done();
  end
endmodule
`default_nettype wire
